// *** esq_sequencer.sv ***
// mode sequencer, measurement flow, iir filtering and apb registers
// assumes a conversion front end answering conv_req with conv_done
`default_nettype none
module esq_sequencer #(
  parameter int SB_BASE_CYC = esq_pkg::ESQ_SB_BASE_CYC
) (
  input wire logic pclk, // 125 MHz clock
  input wire logic presetn, // async reset, active low
  input wire logic ce, // clock enable, freezes state when low
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb direction
  input wire logic [7:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error for unmapped address
  output logic conv_req, // conversion request level
  output logic [1:0] conv_chan, // 0 temp, 1 press, 2 hum
  output logic [2:0] conv_osrs, // oversampling for the conversion
  input wire logic conv_done, // conversion finished pulse
  input wire logic [19:0] conv_data, // conversion result, msb aligned
  output logic measuring // measurement period running
);
  import esq_pkg::*;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic [2:0] osrs_h;
    logic [2:0] osrs_t;
    logic [2:0] osrs_p;
    logic [1:0] mode;
    logic [2:0] sb_sel;
    logic [2:0] filt_sel;
    logic pend;
    logic [1:0] pend_mode;
    esq_state_t fsm;
    logic [31:0] cnt;
    logic [19:0] t_mem;
    logic [19:0] p_mem;
    logic t_init;
    logic p_init;
    logic [19:0] t_out;
    logic [19:0] p_out;
    logic [15:0] h_out;
    logic conv_req;
    logic [1:0] conv_chan;
    logic [2:0] conv_osrs;
    logic measuring;
  } esq_st_t;

  localparam esq_st_t ESQ_ST_RESET = '{
    fsm: MS_IDLE, t_init: 1'b1, p_init: 1'b1,
    t_out: ESQ_SKIP_TP, p_out: ESQ_SKIP_TP, h_out: ESQ_SKIP_H,
    mode: ESQ_MODE_SLEEP, default: '0};

  esq_st_t st_reg;
  esq_st_t st_next;
  esq_filt_if fif ();
  logic acc;
  logic wr;
  logic busy;
  logic end_period;
  logic [31:0] sb_cycles;
  logic [19:0] filt_res;
  logic [2:0] cur_osrs;
  logic is_t;
  logic cfg_wr;
  logic srst;

  esq_iir u_iir (
    .f(fif)
  );

  // access phase, completed on the second cycle
  assign acc = psel && penable && st_reg.pready;
  assign wr = acc && pwrite;
  assign busy = (st_reg.fsm == MS_TEMP) || (st_reg.fsm == MS_PRESS) ||
                (st_reg.fsm == MS_HUM);
  assign sb_cycles = 32'(esq_sb_steps(st_reg.sb_sel)) * 32'(SB_BASE_CYC);

  // config writes restart the filter; the reset command reinitialises
  assign cfg_wr = wr && (paddr == ESQ_OFF_CONFIG);
  assign srst = wr && (paddr == ESQ_OFF_RESET) &&
                (pwdata[7:0] == ESQ_SOFT_RESET_CMD);

  // filter operand selection for temperature or pressure
  assign is_t = (st_reg.fsm == MS_TEMP);
  assign cur_osrs = is_t ? st_reg.osrs_t : st_reg.osrs_p;
  assign fif.mem = is_t ? st_reg.t_mem : st_reg.p_mem;
  assign fif.adc = conv_data;
  assign fif.shift = (is_t ? st_reg.t_init : st_reg.p_init) ? 3'h0 :
                     esq_filt_shift(st_reg.filt_sel);
  assign filt_res = fif.result;
  assign end_period = (st_reg.fsm == MS_HUM) &&
                      ((st_reg.osrs_h == 3'h0) ||
                       (st_reg.conv_req && conv_done));

  // next state: bus, configuration and measurement sequencing
  always_comb
  begin
    st_next = st_reg;
    st_next.pready = psel && penable && !st_reg.pready;
    st_next.pslverr = 1'b0;
    // register reads
    if (psel && penable && !st_reg.pready)
    begin
      st_next.prdata = 32'h0000_0000;
      case (paddr)
        ESQ_OFF_CTRL_HUM: st_next.prdata[2:0] = st_reg.osrs_h;
        ESQ_OFF_CTRL_MEAS: st_next.prdata[7:0] =
          {st_reg.osrs_t, st_reg.osrs_p, st_reg.mode};
        ESQ_OFF_CONFIG: st_next.prdata[7:0] =
          {st_reg.sb_sel, st_reg.filt_sel, 2'h0};
        ESQ_OFF_STATUS: st_next.prdata[3:0] =
          {st_reg.pend_mode, st_reg.pend, st_reg.measuring};
        ESQ_OFF_PRESS: st_next.prdata[19:0] = st_reg.p_out;
        ESQ_OFF_TEMP: st_next.prdata[19:0] = st_reg.t_out;
        ESQ_OFF_HUM: st_next.prdata[15:0] = st_reg.h_out;
        ESQ_OFF_RESET: st_next.prdata = 32'h0000_0000;
        default: st_next.pslverr = 1'b1;
      endcase
    end
    // register writes, any mode keeps them accessible
    if (wr)
    begin
      case (paddr)
        ESQ_OFF_CTRL_HUM:
          if (!st_reg.pend)
            st_next.osrs_h = pwdata[ESQ_OSRS_H_LSB +: 3];
        ESQ_OFF_CTRL_MEAS:
        begin
          st_next.osrs_t = pwdata[ESQ_OSRS_T_LSB +: 3];
          st_next.osrs_p = pwdata[ESQ_OSRS_P_LSB +: 3];
          if (!st_reg.pend)
          begin
            if (busy)
            begin
              st_next.pend = 1'b1;
              st_next.pend_mode = pwdata[ESQ_MODE_LSB +: 2];
            end
            else
              st_next.mode = pwdata[ESQ_MODE_LSB +: 2];
          end
        end
        ESQ_OFF_CONFIG:
        begin
          st_next.sb_sel = pwdata[ESQ_SB_LSB +: 3];
          st_next.filt_sel = pwdata[ESQ_FILT_LSB +: 3];
          st_next.t_init = 1'b1;
          st_next.p_init = 1'b1;
        end
        default: ;
      endcase
    end
    // a change noted on the edge that ended the period applies now
    if (st_reg.pend && !busy)
    begin
      st_next.mode = st_reg.pend_mode;
      st_next.pend = 1'b0;
    end
    // measurement flow: temperature, pressure, humidity
    case (st_reg.fsm)
      MS_IDLE:
        if (st_reg.mode != ESQ_MODE_SLEEP)
          st_next.fsm = MS_TEMP;
      MS_TEMP, MS_PRESS:
        if (cur_osrs == 3'h0)
        begin
          // skipped: memory kept, output marked
          if (is_t)
            st_next.t_out = ESQ_SKIP_TP;
          else
            st_next.p_out = ESQ_SKIP_TP;
          // a setting cleared mid-conversion withdraws the request
          st_next.conv_req = 1'b0;
          st_next.fsm = is_t ? MS_PRESS : MS_HUM;
        end
        else if (!st_reg.conv_req)
        begin
          st_next.conv_req = 1'b1;
          st_next.conv_chan = is_t ? 2'h0 : 2'h1;
          st_next.conv_osrs = cur_osrs;
        end
        else if (conv_done)
        begin
          st_next.conv_req = 1'b0;
          if (is_t)
          begin
            st_next.t_mem = filt_res;
            st_next.t_out = esq_resolve(filt_res, st_reg.osrs_t,
              st_reg.filt_sel != 3'h0 && !st_reg.t_init);
            st_next.t_init = cfg_wr;
          end
          else
          begin
            st_next.p_mem = filt_res;
            st_next.p_out = esq_resolve(filt_res, st_reg.osrs_p,
              st_reg.filt_sel != 3'h0 && !st_reg.p_init);
            st_next.p_init = cfg_wr;
          end
          st_next.fsm = is_t ? MS_PRESS : MS_HUM;
        end
      MS_HUM:
        if (st_reg.osrs_h == 3'h0)
        begin
          st_next.h_out = ESQ_SKIP_H;
          st_next.conv_req = 1'b0;
        end
        else if (!st_reg.conv_req)
        begin
          st_next.conv_req = 1'b1;
          st_next.conv_chan = 2'h2;
          st_next.conv_osrs = st_reg.osrs_h;
        end
        else if (conv_done)
        begin
          st_next.conv_req = 1'b0;
          st_next.h_out = conv_data[19:4];
        end
      MS_STBY:
        if (st_reg.mode != ESQ_MODE_NORMAL)
          st_next.fsm = MS_IDLE;
        else if (st_reg.cnt == 32'h0)
          st_next.fsm = MS_TEMP;
        else
          st_next.cnt = st_reg.cnt - 32'h1;
      default: st_next.fsm = MS_IDLE;
    endcase
    // period end: apply pending mode, forced falls back to sleep
    if (end_period)
    begin
      if (st_reg.pend)
      begin
        st_next.mode = st_reg.pend_mode;
        st_next.pend = 1'b0;
      end
      else if (st_reg.mode != ESQ_MODE_NORMAL)
        st_next.mode = ESQ_MODE_SLEEP;
      if (st_next.mode == ESQ_MODE_NORMAL)
      begin
        st_next.fsm = MS_STBY;
        st_next.cnt = sb_cycles - 32'h1;
      end
      else
        st_next.fsm = MS_IDLE;
    end
    st_next.measuring = (st_next.fsm == MS_TEMP) ||
      (st_next.fsm == MS_PRESS) || (st_next.fsm == MS_HUM);
    // soft reset command reinitialises everything
    if (srst)
    begin
      // the access is answered on this edge, so pready drops as well
      st_next = ESQ_ST_RESET;
    end
  end

  // state register, frozen while ce is low
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      st_reg <= ESQ_ST_RESET;
    else if (ce)
      st_reg <= st_next;
  end

  assign prdata = st_reg.prdata;
  assign pready = st_reg.pready;
  assign pslverr = st_reg.pslverr;
  assign conv_req = st_reg.conv_req;
  assign conv_chan = st_reg.conv_chan;
  assign conv_osrs = st_reg.conv_osrs;
  assign measuring = st_reg.measuring;

  // checks on the sequencing and filter behaviour
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_pend_hold;
    ce && !srst && st_reg.pend && busy && !end_period
      |=> $stable(st_reg.mode);
  endproperty
  a_pend_hold: assert property (p_pend_hold)
    else $error("mode changed before period end");

  property p_hum_blocked;
    ce && st_reg.pend && wr && paddr == ESQ_OFF_CTRL_HUM
      |=> $stable(st_reg.osrs_h);
  endproperty
  a_hum_blocked: assert property (p_hum_blocked)
    else $error("humidity control written while change pending");

  property p_forced_sleep;
    ce && end_period && !st_reg.pend &&
      st_reg.mode != ESQ_MODE_NORMAL |=> st_reg.mode == ESQ_MODE_SLEEP;
  endproperty
  a_forced_sleep: assert property (p_forced_sleep)
    else $error("forced period did not return to sleep");

  property p_sleep_quiet;
    st_reg.mode == ESQ_MODE_SLEEP && st_reg.fsm == MS_IDLE |-> !conv_req;
  endproperty
  a_sleep_quiet: assert property (p_sleep_quiet)
    else $error("conversion requested in sleep");

  property p_temp_skip;
    ce && !srst && st_reg.fsm == MS_TEMP && st_reg.osrs_t == 3'h0
      |=> st_reg.t_out == ESQ_SKIP_TP && $stable(st_reg.t_mem);
  endproperty
  a_temp_skip: assert property (p_temp_skip)
    else $error("skipped temperature not marked");

  property p_hum_skip;
    ce && st_reg.fsm == MS_HUM && st_reg.osrs_h == 3'h0
      |=> st_reg.h_out == ESQ_SKIP_H;
  endproperty
  a_hum_skip: assert property (p_hum_skip)
    else $error("skipped humidity not marked");

  property p_filter_restart;
    ce && wr && paddr == ESQ_OFF_CONFIG |=> st_reg.t_init && st_reg.p_init;
  endproperty
  a_filter_restart: assert property (p_filter_restart)
    else $error("filter not restarted on config write");

  property p_normal_repeat;
    ce && !srst && st_reg.fsm == MS_STBY && st_reg.cnt == 32'h0 &&
      st_reg.mode == ESQ_MODE_NORMAL |=> st_reg.fsm == MS_TEMP;
  endproperty
  a_normal_repeat: assert property (p_normal_repeat)
    else $error("normal mode did not restart measurement");

  property p_order;
    ce && !srst && st_reg.fsm == MS_TEMP
      |=> st_reg.fsm inside {MS_TEMP, MS_PRESS};
  endproperty
  a_order: assert property (p_order)
    else $error("temperature not followed by pressure");

  c_forced_done: cover property (ce && end_period &&
    st_reg.mode != ESQ_MODE_NORMAL);
  c_standby: cover property (st_reg.fsm == MS_STBY ##1
    st_reg.fsm == MS_TEMP);
  c_pending: cover property (st_reg.pend ##[1:200] !st_reg.pend);
endmodule
`default_nettype wire

// *** esq_pkg.sv ***
// constants, types and helpers for the environmental sensor sequencer
// assumes a single pclk domain and an external conversion front end
// Functional notes
// - reset brings all logic up in sleep
// - soft reset command or supply cycle resets
// - three modes chosen by mode bits 1:0
// - mode change during measurement waits period end
// - pending change blocks mode and humidity writes
// - sleep runs nothing, registers stay accessible
// - forced runs one period, then sleeps
// - normal repeats measurement and standby forever
// - normal keeps refreshing the data registers
// - period converts temperature, pressure, then humidity
// - filter on pressure, temperature; humidity bypasses
// - humidity skip or oversample, 16-bit result
// - pressure skip/enable, resolution by filter, oversampling
// - temperature resolution by filter and oversampling
// - temperature skip or chosen oversampling ratio
// - filtered equals old times (c-1) plus adc, over c
// - filtered value updates memory and output
// - filter coefficient off, 2, 4, 8, 16
// - filter setting write restarts the filter
// - skipped temperature or pressure keeps memory, outputs 0x80000; skipped humidity outputs 0x8000
// - reenabled channel filters against retained memory
`default_nettype none
package esq_pkg;
  // register byte offsets
  localparam logic [7:0] ESQ_OFF_CTRL_HUM = 8'h00;
  localparam logic [7:0] ESQ_OFF_CTRL_MEAS = 8'h04;
  localparam logic [7:0] ESQ_OFF_CONFIG = 8'h08;
  localparam logic [7:0] ESQ_OFF_STATUS = 8'h0c;
  localparam logic [7:0] ESQ_OFF_PRESS = 8'h10;
  localparam logic [7:0] ESQ_OFF_TEMP = 8'h14;
  localparam logic [7:0] ESQ_OFF_HUM = 8'h18;
  localparam logic [7:0] ESQ_OFF_RESET = 8'h1c;
  // field positions
  localparam int ESQ_MODE_LSB = 0;
  localparam int ESQ_OSRS_P_LSB = 2;
  localparam int ESQ_OSRS_T_LSB = 5;
  localparam int ESQ_FILT_LSB = 2;
  localparam int ESQ_SB_LSB = 5;
  localparam int ESQ_OSRS_H_LSB = 0;
  // mode encodings and soft reset command
  localparam logic [1:0] ESQ_MODE_SLEEP = 2'h0;
  localparam logic [1:0] ESQ_MODE_NORMAL = 2'h3;
  localparam logic [7:0] ESQ_SOFT_RESET_CMD = 8'hb6;
  // values loaded for skipped channels
  localparam logic [19:0] ESQ_SKIP_TP = 20'h80000;
  localparam logic [15:0] ESQ_SKIP_H = 16'h8000;
  // standby base step of 0.5 ms at 125 MHz
  localparam int ESQ_CLK_MHZ = 125;
  localparam int ESQ_SB_BASE_US = 500;
  localparam int ESQ_SB_BASE_CYC = ESQ_SB_BASE_US * ESQ_CLK_MHZ;

  typedef enum logic [2:0] {
    MS_IDLE, MS_TEMP, MS_PRESS, MS_HUM, MS_STBY
  } esq_state_t;

  // standby length in 0.5 ms steps, 0.5 ms up to 1000 ms
  function automatic logic [11:0] esq_sb_steps(input logic [2:0] sel);
    case (sel)
      3'h0: esq_sb_steps = 12'h001;
      3'h1: esq_sb_steps = 12'h07d;
      3'h2: esq_sb_steps = 12'h0fa;
      3'h3: esq_sb_steps = 12'h1f4;
      3'h4: esq_sb_steps = 12'h3e8;
      3'h5: esq_sb_steps = 12'h7d0;
      3'h6: esq_sb_steps = 12'h014;
      default: esq_sb_steps = 12'h028;
    endcase
  endfunction

  // filter shift: 0 off, then coefficient 2, 4, 8, 16
  function automatic logic [2:0] esq_filt_shift(input logic [2:0] sel);
    esq_filt_shift = (sel > 3'h4) ? 3'h4 : sel;
  endfunction

  // keep 16 + (osrs - 1) bits when the filter is off, 20 when on
  function automatic logic [19:0] esq_resolve(input logic [19:0] v,
      input logic [2:0] osrs, input logic filt_on);
    logic [2:0] eff;
    eff = (osrs > 3'h5) ? 3'h5 : osrs;
    if (filt_on)
      esq_resolve = v;
    else
      esq_resolve = v & (20'hfffff << (3'h5 - eff));
  endfunction
endpackage
`default_nettype wire

// *** esq_filt_if.sv ***
// carrier between the sequencer and its iir filter datapath
// assumes combinational use within one pclk cycle
`default_nettype none
interface esq_filt_if;
  logic [19:0] mem;
  logic [19:0] adc;
  logic [2:0] shift;
  logic [19:0] result;
  modport user (output mem, output adc, output shift, input result);
  modport filt (input mem, input adc, input shift, output result);
endinterface
`default_nettype wire

// *** esq_iir.sv ***
// iir low-pass datapath: (old * (c - 1) + adc) / c with c = 2^shift
// assumes the caller forces shift to zero for a pass-through sample
`default_nettype none
module esq_iir (
  esq_filt_if.filt f // filter operands and result
);
  import esq_pkg::*;
  logic [24:0] sum;
  logic [24:0] quot;

  // weighted sum, truncating divide by 2^shift
  always_comb
  begin
    sum = ({5'h00, f.mem} << f.shift) - {5'h00, f.mem} + {5'h00, f.adc};
    quot = sum >> f.shift;
    if (f.shift == 3'h0)
      f.result = f.adc;
    else
      f.result = quot[19:0];
  end
endmodule
`default_nettype wire

// *** esq_conv_model.sv ***
// conversion front end model answering conv_req with a conv_done pulse
// assumes the sequencer holds conv_req and conv_chan until conv_done
`default_nettype none
module esq_conv_model (
  input wire logic pclk, // clock
  input wire logic presetn, // async reset, active low
  input wire logic conv_req, // conversion wanted
  input wire logic [1:0] conv_chan, // channel asked for
  input wire logic [19:0] t_val, // temperature sample
  input wire logic [19:0] p_val, // pressure sample
  input wire logic [19:0] h_val, // humidity sample
  output logic conv_done, // result pulse
  output logic [19:0] conv_data // result, scrambled outside the pulse
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] cnt;
  logic slow;
  // alternate quick and slow answers; data is inverted when not valid
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt <= 4'h0;
      slow <= 1'b0;
      conv_done <= 1'b0;
      conv_data <= 20'h0;
    end
    else if (conv_req && !conv_done && cnt == (slow ? 4'hf : 4'h3))
    begin
      conv_done <= 1'b1;
      cnt <= 4'h0;
      slow <= !slow;
      conv_data <= (conv_chan == 2'h0) ? t_val :
                   (conv_chan == 2'h1) ? p_val : h_val;
    end
    else
    begin
      conv_done <= 1'b0;
      conv_data <= ~conv_data;
      if (conv_req && !conv_done)
        cnt <= cnt + 4'h1;
    end
  end
endmodule
`default_nettype wire

// *** tb.sv ***
// self-checking bench: apb register access and measurement sequencing
// assumes esq_conv_model stands in for the conversion front end
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import esq_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic ce = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic conv_req;
  logic [1:0] conv_chan;
  logic [2:0] conv_osrs;
  logic [2:0] osrs_exp[3] = '{3'h0, 3'h0, 3'h0};
  logic conv_done;
  logic [19:0] conv_data;
  logic measuring;
  logic [19:0] t_val = 20'h0;
  logic [19:0] p_val = 20'h0;
  logic [19:0] h_val = 20'h0;
  logic [31:0] seed = 32'h5b98;
  logic [32:0] notes[$];
  int errors = 0;
  int n_compared = 0;

  esq_sequencer #(.SB_BASE_CYC(4)) esq_sequencer_i (.pclk(pclk),
    .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .conv_req(conv_req),
    .conv_chan(conv_chan), .conv_osrs(conv_osrs), .conv_done(conv_done),
    .conv_data(conv_data), .measuring(measuring));
  esq_conv_model esq_conv_model_i (.pclk(pclk), .presetn(presetn),
    .conv_req(conv_req), .conv_chan(conv_chan), .t_val(t_val),
    .p_val(p_val), .h_val(h_val), .conv_done(conv_done),
    .conv_data(conv_data));

  // 125 MHz clock
  always #4 pclk = ~pclk;

  task automatic stop_test;
    $display("compared %0d, mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic check(input logic [32:0] seen, input logic [32:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      errors++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic guard(input int n);
    if (n > 2000)
    begin
      errors++;
      $display("MISMATCH t=%0t wait limit reached", $time);
      stop_test();
    end
  endtask

  // one apb transfer: setup, access held until pready is sampled high
  task automatic xfer(input logic w, input logic [7:0] a,
      input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
      guard(n);
    end
    while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask

  // note {pslverr, prdata} expected, then read
  task automatic rd(input logic [7:0] a, input logic [32:0] exp);
    notes.push_back(exp);
    xfer(1'b0, a, 32'h0);
  endtask

  // compare each completed read against the oldest note
  always @(posedge pclk)
    if (psel && penable && pready && !pwrite)
      check({pslverr, prdata}, notes.pop_front());

  // each answered conversion ran at the oversampling last written
  always @(posedge pclk)
    if (conv_req && conv_done)
      check({30'h0, conv_osrs}, {30'h0, osrs_exp[conv_chan]});

  task automatic wait_meas(input logic lvl);
    int n;
    n = 0;
    while (measuring !== lvl)
    begin
      @(posedge pclk);
      n++;
      guard(n);
    end
  endtask

  task automatic period;
    wait_meas(1'b1);
    wait_meas(1'b0);
  endtask

  task automatic run(input logic [31:0] w);
    osrs_exp[0] = w[7:5];
    osrs_exp[1] = w[4:2];
    wr(ESQ_OFF_CTRL_MEAS, w);
    period();
  endtask

  function automatic logic [19:0] rnd();
    repeat (20)
      seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed[19:0];
  endfunction

  task automatic new_vals;
    t_val <= rnd();
    p_val <= rnd();
    h_val <= rnd();
  endtask

  function automatic logic [31:0] meas(input logic [2:0] t,
      input logic [2:0] p, input logic [1:0] m);
    return {24'h0, t, p, m};
  endfunction

  // expected iir output with coefficient 2^k, truncating
  function automatic logic [32:0] filt(input logic [19:0] old,
      input logic [19:0] adc, input int k);
    logic [27:0] s;
    s = ((28'(old) << k) - 28'(old) + 28'(adc)) >> k;
    return {13'h0, s[19:0]};
  endfunction

  // main sequence
  initial
  begin
    logic [19:0] a;
    logic [19:0] b;
    logic saw;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    rd(ESQ_OFF_STATUS, 33'h0);
    rd(ESQ_OFF_TEMP, {13'h0, ESQ_SKIP_TP});
    rd(ESQ_OFF_HUM, {17'h0, ESQ_SKIP_H});
    rd(8'h20, {1'b1, 32'h0});
    wr(ESQ_OFF_CTRL_HUM, 32'h1);
    osrs_exp[2] = 3'h1;
    // filter settings 0 to 4: restart, first sample, filtered sample
    for (int k = 0; k < 5; k++)
    begin
      wr(ESQ_OFF_CONFIG, 32'(k << 2));
      new_vals();
      run(meas(3'h5, 3'h5, 2'h1));
      a = t_val;
      b = p_val;
      rd(ESQ_OFF_TEMP, {13'h0, a});
      rd(ESQ_OFF_PRESS, {13'h0, b});
      new_vals();
      run(meas(3'h5, 3'h5, 2'h2));
      rd(ESQ_OFF_TEMP, filt(a, t_val, k));
      rd(ESQ_OFF_PRESS, filt(b, p_val, k));
      rd(ESQ_OFF_HUM, {17'h0, h_val[19:4]});
    end
    rd(ESQ_OFF_CTRL_MEAS, 33'hb4);
    // skipped channels keep memory, re-enabled temp filters on it
    a = 20'(filt(a, t_val, 4));
    wr(ESQ_OFF_CTRL_HUM, 32'h0);
    run(meas(3'h0, 3'h5, 2'h1));
    rd(ESQ_OFF_TEMP, {13'h0, ESQ_SKIP_TP});
    rd(ESQ_OFF_HUM, {17'h0, ESQ_SKIP_H});
    new_vals();
    run(meas(3'h5, 3'h5, 2'h1));
    rd(ESQ_OFF_TEMP, filt(a, t_val, 4));
    // filter off resolution follows oversampling
    wr(ESQ_OFF_CONFIG, 32'h0);
    run(meas(3'h3, 3'h1, 2'h1));
    rd(ESQ_OFF_TEMP, {13'h0, t_val & 20'hffffc});
    rd(ESQ_OFF_PRESS, {13'h0, p_val & 20'hffff0});
    // normal mode refreshes data each period
    run(meas(3'h5, 3'h5, 2'h3));
    a = t_val;
    new_vals();
    // ce low freezes the standby count, so no period may start
    ce <= 1'b0;
    saw = 1'b0;
    repeat (30)
    begin
      @(posedge pclk);
      saw = saw | measuring;
    end
    ce <= 1'b1;
    check({32'h0, saw}, 33'h0);
    rd(ESQ_OFF_TEMP, {13'h0, a});
    period();
    rd(ESQ_OFF_TEMP, {13'h0, t_val});
    // mode change during a period waits, blocks further mode and humidity writes
    wait_meas(1'b1);
    wr(ESQ_OFF_CTRL_MEAS, meas(3'h5, 3'h5, 2'h0));
    rd(ESQ_OFF_STATUS, 33'h3);
    wr(ESQ_OFF_CTRL_HUM, 32'h3);
    wr(ESQ_OFF_CTRL_MEAS, meas(3'h5, 3'h5, 2'h3));
    rd(ESQ_OFF_CTRL_HUM, 33'h0);
    wait_meas(1'b0);
    saw = 1'b0;
    repeat (40)
    begin
      @(posedge pclk);
      saw = saw | measuring;
    end
    check({32'h0, saw}, 33'h0);
    rd(ESQ_OFF_CTRL_MEAS, 33'hb4);
    // soft reset returns settings to reset values
    wr(ESQ_OFF_CONFIG, 32'he4);
    wr(ESQ_OFF_RESET, 32'(ESQ_SOFT_RESET_CMD));
    rd(ESQ_OFF_CTRL_MEAS, 33'h0);
    rd(ESQ_OFF_CONFIG, 33'h0);
    rd(ESQ_OFF_PRESS, {13'h0, ESQ_SKIP_TP});
    repeat (2) @(posedge pclk);
    stop_test();
  end
endmodule
`default_nettype wire
